// File: rtl/dhis_pkg.sv
// dhis_pkg: shared constants for the dac host interface select block
// assumes a 50 MHz system clock and a separate serial link clock
`default_nettype none
package dhis_pkg;
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned NUM_CHANNELS  = 40;
    localparam int unsigned ADDR_W        = 6;
    localparam int unsigned DATA_W        = 12;
    localparam int unsigned SPI_FRAME_W   = 24;
    // bit positions of the shared pins within the parallel word
    localparam int unsigned PIN_PROTO_SEL = 9;
    localparam int unsigned PIN_SER_CLK   = 10;
    localparam int unsigned PIN_SER_DATA  = 11;
    // spi frame layout: toggle-b, reg select, channel, data
    localparam int unsigned SPI_AB_POS    = 23;
    localparam int unsigned SPI_REG_POS   = 20;
    localparam int unsigned SPI_CH_POS    = 12;
    // i2c bus address: upper five bits fixed, low two from pins
    localparam logic [4:0]  I2C_ADDR_BASE = 5'h15;
    localparam logic [6:0]  I2C_ADDR_RST  = 7'h00;
    localparam int unsigned I2C_STD_HZ    = 100_000;
    localparam int unsigned I2C_FAST_HZ   = 400_000;
    // i2c glitch filter length: cycles of clk well under a fast-mode low phase
    localparam int unsigned I2C_LOW_NS    = 1300;
    localparam int unsigned I2C_FILT_CYC  = (I2C_LOW_NS * (CLK_HZ / 1_000_000)) / 1000 / 8;
    localparam logic [1:0]  REG_SFR       = 2'h0;
    localparam logic [1:0]  REG_GAIN      = 2'h1;
    localparam logic [1:0]  REG_OFFSET    = 2'h2;
    localparam logic [1:0]  REG_DATA      = 2'h3;
    localparam logic [1:0]  PD_HIGH_Z     = 2'h0;
    localparam logic [1:0]  PD_LOAD_100K  = 2'h1;
    localparam logic [1:0]  PD_ACTIVE     = 2'h2;
    typedef enum logic [1:0] {DHIS_PARALLEL, DHIS_SPI, DHIS_I2C} dhis_mode_t;
    typedef enum logic [1:0] {DHIS_DST_SFR, DHIS_DST_GAIN, DHIS_DST_OFFSET, DHIS_DST_DATA}
        dhis_dst_t;
endpackage
`default_nettype wire

// File: rtl/dhis_spi_link.sv
// dhis_spi_link: spi shift register on the link clock
// assumes the frame sync is low for a whole frame; the link clock may stop between frames
`default_nettype none
module dhis_spi_link (
    input  wire logic                                sclk,
    input  wire logic                                rst,
    input  wire logic                                frame_sync_n,
    input  wire logic                                enable,
    input  wire logic                                chain_enable,
    input  wire logic                                din,
    output logic                                     serial_out,
    output logic                                     serial_out_oe,
    output logic [dhis_pkg::SPI_FRAME_W-1:0]         frame_q,
    output logic                                     frame_tgl_q
);
    logic [dhis_pkg::SPI_FRAME_W-1:0] shift_q, shift_d;
    logic [4:0]                       cnt_q, cnt_d;
    logic [dhis_pkg::SPI_FRAME_W-1:0] frame_d;
    logic                             tgl_d;
    logic                             out_q;
    logic                             clr;

    always_comb begin
        shift_d = shift_q;
        cnt_d   = cnt_q;
        frame_d = frame_q;
        tgl_d   = frame_tgl_q;
        if (enable && !frame_sync_n) begin
            shift_d = {shift_q[dhis_pkg::SPI_FRAME_W-2:0], din};
            if (cnt_q == 5'(dhis_pkg::SPI_FRAME_W - 1)) begin
                cnt_d   = 5'h00;
                frame_d = shift_d;
                tgl_d   = ~frame_tgl_q; // event crosses as a toggle
            end else begin
                cnt_d = cnt_q + 5'h01;
            end
        end else begin
            cnt_d = 5'h00;
        end
    end

    // sync high clears the count, so a cut frame never skews the next one
    assign clr = frame_sync_n | rst;

    // falling edge capture; link clock may stand still, so resets act as levels
    always_ff @(negedge sclk or posedge clr) begin
        if (clr) begin
            shift_q <= '0;
            cnt_q   <= 5'h00;
        end else begin
            shift_q <= shift_d;
            cnt_q   <= cnt_d;
        end
    end

    // toggle must start known or the crossing never sees a frame
    always_ff @(negedge sclk or posedge rst) begin
        if (rst) begin
            frame_q     <= '0;
            frame_tgl_q <= 1'b0;
        end else begin
            frame_q     <= frame_d;
            frame_tgl_q <= tgl_d;
        end
    end

    // launch on rising edge so the next device samples a stable bit
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            out_q <= 1'b0;
        end else begin
            out_q <= shift_q[dhis_pkg::SPI_FRAME_W-1];
        end
    end

    assign serial_out    = out_q;
    assign serial_out_oe = enable && chain_enable && !frame_sync_n;
endmodule
`default_nettype wire

// File: rtl/dhis_top.sv
// dhis_top: host interface front end with strap-selected parallel, spi and i2c ports
// assumes pins are asynchronous to clk; spi clock arrives on its own clock port
//
// What this block does
// - strap high selects serial interface, low selects parallel interface
// - in serial mode, protocol pin low gives spi, high gives i2c
// - data bit 10 is i2c serial clock (spi clock comes on spi_clk), data bit 11 is serial data
// - spi data shifts in on each falling serial clock edge, up to 50 MHz
// - serial output launches on rising edge, three-stateable, for daisy chains
// - i2c port works at 100 kHz and 400 kHz bus rates
// - i2c slave address uses two pins shared with write strobe and chip select
// - i2c data line is open drain: only pulls low, never drives high
// - power-down pin high enters low power; outputs high-z or 100k load
// - serial interface keeps working during power-down
// - parallel mode decodes six address bits to one of forty channels
// - parallel chip select is active low level enable for writes
// - spi mode uses chip select as frame sync
// - toggle mode: a/b pin picks data register a or b; load swaps outputs
// - two data registers per channel; normal mode writes go to register a
// - parallel mode uses shared pins as data bits 9, 10 and 11
// - parallel write captured on write strobe rising edge with chip select low
// - daisy-chain enable high with serial mode enables spi chaining
// - register select picks data, offset, gain or special function registers
`default_nettype none
module dhis_top (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          spi_clk,
    input  wire logic                          interface_kind_strap,
    input  wire logic                          power_down_pin,
    input  wire logic [dhis_pkg::ADDR_W-1:0]   channel_address_inputs,
    input  wire logic                          register_select_high,
    input  wire logic                          register_select_low,
    input  wire logic [dhis_pkg::DATA_W-1:0]   parallel_data_bus,
    output logic                               sda_out,
    output logic                               sda_oe,
    input  wire logic                          write_strobe_n,
    input  wire logic                          chip_select_n,
    input  wire logic                          toggle_enable,
    input  wire logic                          load_outputs_strobe_n,
    input  wire logic [1:0]                    pd_config,
    output logic                               serial_out,
    output logic                               serial_out_oe,
    output logic                               ab_select_oe,
    output logic [1:0]                         mode_q,
    output logic                               wr_valid_q,
    output logic [dhis_pkg::ADDR_W-1:0]        wr_channel_q,
    output logic [1:0]                         wr_register_q,
    output logic                               wr_bank_b_q,
    output logic [dhis_pkg::DATA_W-1:0]        wr_data_q,
    output logic                               bank_b_active_q,
    output logic                               low_power_q,
    output logic [1:0]                         out_stage_q,
    output logic [6:0]                         i2c_address_q
);
    // shared pins: ab select on serial_out pin, chain enable on write strobe
    logic [9:0] s1_q, s2_q;
    logic [9:0] pin_raw;
    assign pin_raw = {load_outputs_strobe_n, chip_select_n, write_strobe_n, power_down_pin,
                      interface_kind_strap, parallel_data_bus[dhis_pkg::PIN_PROTO_SEL],
                      parallel_data_bus[dhis_pkg::PIN_SER_DATA],
                      parallel_data_bus[dhis_pkg::PIN_SER_CLK],
                      register_select_high, register_select_low};
    logic [dhis_pkg::DATA_W-1:0] pd_s1_q, pd_s2_q;
    logic [dhis_pkg::ADDR_W-1:0] a_s1_q, a_s2_q;
    logic ab_s1_q, ab_s2_q, tog_s1_q, tog_s2_q, link_rst_q;

    // two-stage synchronisers; first stage read only by the second
    always_ff @(posedge clk) begin
        s1_q     <= pin_raw;
        s2_q     <= s1_q;
        pd_s1_q  <= parallel_data_bus;
        pd_s2_q  <= pd_s1_q;
        a_s1_q   <= channel_address_inputs;
        a_s2_q   <= a_s1_q;
        ab_s1_q  <= serial_out;
        ab_s2_q  <= ab_s1_q;
        tog_s1_q <= toggle_enable;
        tog_s2_q <= tog_s1_q;
        // registered copy gives the link a clean edge even if rst starts high
        link_rst_q <= rst;
    end

    logic ld_n, cs_n, wr_n, pd, ser, proto, sda_in, scl_in, rs_hi, rs_lo;
    assign {ld_n, cs_n, wr_n, pd, ser, proto, sda_in, scl_in, rs_hi, rs_lo} = s2_q;

    function automatic logic [1:0] dhis_pick_mode(input logic ser_i, input logic proto_i);
        if (!ser_i) begin
            return 2'(dhis_pkg::DHIS_PARALLEL);
        end
        return proto_i ? 2'(dhis_pkg::DHIS_I2C) : 2'(dhis_pkg::DHIS_SPI);
    endfunction

    // ---------------- mode, power-down and parallel write ----------------
    logic [1:0]                  mode_d, out_stage_d, wr_register_d;
    logic                        wr_valid_d, wr_bank_b_d, bank_b_d, low_power_d, wr_prev_q;
    logic [dhis_pkg::ADDR_W-1:0] wr_channel_d;
    logic [dhis_pkg::DATA_W-1:0] wr_data_d;
    logic [6:0]                  i2c_address_d;
    logic                        ld_prev_q, spi_frame_pulse;
    logic [dhis_pkg::SPI_FRAME_W-1:0] spi_frame;
    logic                        wr_rise, ld_fall, is_par, is_spi, is_i2c;

    assign is_par  = mode_q == 2'(dhis_pkg::DHIS_PARALLEL);
    assign is_spi  = mode_q == 2'(dhis_pkg::DHIS_SPI);
    assign is_i2c  = mode_q == 2'(dhis_pkg::DHIS_I2C);
    assign wr_rise = wr_n && !wr_prev_q;
    assign ld_fall = !ld_n && ld_prev_q;

    always_comb begin
        mode_d        = dhis_pick_mode(ser, proto);
        low_power_d   = pd;
        out_stage_d   = pd ? pd_config : dhis_pkg::PD_ACTIVE;
        wr_valid_d    = 1'b0;
        wr_channel_d  = wr_channel_q;
        wr_register_d = wr_register_q;
        wr_bank_b_d   = wr_bank_b_q;
        wr_data_d     = wr_data_q;
        bank_b_d      = bank_b_active_q;
        i2c_address_d = {dhis_pkg::I2C_ADDR_BASE, wr_n, cs_n};
        // parallel strobes count only in parallel mode
        if (is_par && wr_rise && !cs_n && !pd) begin
            wr_valid_d    = 1'b1;
            wr_channel_d  = a_s2_q;
            wr_register_d = {rs_hi, rs_lo};
            wr_bank_b_d   = tog_s2_q && ab_s2_q;
            wr_data_d     = pd_s2_q;
        end else if (is_spi && spi_frame_pulse) begin
            wr_valid_d    = 1'b1;
            wr_channel_d  = spi_frame[dhis_pkg::SPI_CH_POS +: dhis_pkg::ADDR_W];
            wr_register_d = spi_frame[dhis_pkg::SPI_REG_POS +: 2];
            wr_bank_b_d   = tog_s2_q && spi_frame[dhis_pkg::SPI_AB_POS];
            wr_data_d     = spi_frame[dhis_pkg::DATA_W-1:0];
        end
        if (ld_fall && tog_s2_q) begin
            bank_b_d = ~bank_b_active_q;
        end else if (!tog_s2_q) begin
            bank_b_d = 1'b0;
        end
        if (wr_valid_d && wr_channel_d >= 6'(dhis_pkg::NUM_CHANNELS)
            && wr_register_d != dhis_pkg::REG_SFR) begin
            wr_valid_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q          <= 2'h0;
            low_power_q     <= 1'b0;
            out_stage_q     <= dhis_pkg::PD_ACTIVE;
            wr_valid_q      <= 1'b0;
            wr_channel_q    <= '0;
            wr_register_q   <= 2'h0;
            wr_bank_b_q     <= 1'b0;
            wr_data_q       <= '0;
            bank_b_active_q <= 1'b0;
            i2c_address_q   <= dhis_pkg::I2C_ADDR_RST;
            wr_prev_q       <= 1'b1;
            ld_prev_q       <= 1'b1;
        end else begin
            mode_q          <= mode_d;
            low_power_q     <= low_power_d;
            out_stage_q     <= out_stage_d;
            wr_valid_q      <= wr_valid_d;
            wr_channel_q    <= wr_channel_d;
            wr_register_q   <= wr_register_d;
            wr_bank_b_q     <= wr_bank_b_d;
            wr_data_q       <= wr_data_d;
            bank_b_active_q <= bank_b_d;
            i2c_address_q   <= i2c_address_d;
            wr_prev_q       <= wr_n;
            ld_prev_q       <= ld_n;
        end
    end

    // ---------------- spi link and crossing ----------------
    logic [dhis_pkg::SPI_FRAME_W-1:0] link_frame;
    logic link_tgl, tgl_s1_q, tgl_s2_q, tgl_s3_q, spi_en, spi_so, spi_so_oe;
    assign spi_en = ser && !proto;

    dhis_spi_link u_link (
        .sclk          (spi_clk),
        .rst           (link_rst_q),
        .frame_sync_n  (chip_select_n),
        .enable        (spi_en),
        .chain_enable  (write_strobe_n),
        .din           (parallel_data_bus[dhis_pkg::PIN_SER_DATA]),
        .serial_out    (spi_so),
        .serial_out_oe (spi_so_oe),
        .frame_q       (link_frame),
        .frame_tgl_q   (link_tgl)
    );

    // frame word is stable long after the toggle is seen, so it is sampled directly
    always_ff @(posedge clk) begin
        tgl_s1_q <= link_tgl;
        tgl_s2_q <= tgl_s1_q;
        tgl_s3_q <= tgl_s2_q;
    end
    assign spi_frame_pulse = tgl_s2_q ^ tgl_s3_q;
    assign spi_frame       = link_frame;
    assign serial_out      = spi_so;
    assign serial_out_oe   = spi_so_oe && is_spi;
    assign ab_select_oe    = 1'b0;

    // ---------------- i2c address acknowledge ----------------
    typedef enum logic [2:0] {DHIS_I_IDLE, DHIS_I_ADDR, DHIS_I_ACK, DHIS_I_SKIP} dhis_i2c_t;
    dhis_i2c_t   ist_q, ist_d;
    logic [7:0]  ish_q, ish_d;
    logic [3:0]  ibit_q, ibit_d;
    logic        scl_prev_q, sda_prev_q, pull_q, pull_d;
    logic        scl_rise, scl_fall, start_c, stop_c;
    assign scl_rise = scl_in && !scl_prev_q; // sampled at 50 MHz, ample for 400 kHz
    assign scl_fall = !scl_in && scl_prev_q;
    assign start_c  = scl_in && scl_prev_q && sda_prev_q && !sda_in;
    assign stop_c   = scl_in && scl_prev_q && !sda_prev_q && sda_in;

    always_comb begin
        ist_d  = ist_q;
        ish_d  = ish_q;
        ibit_d = ibit_q;
        pull_d = pull_q;
        if (!is_i2c || stop_c) begin
            ist_d  = DHIS_I_IDLE;
            pull_d = 1'b0;
        end else if (start_c) begin
            ist_d  = DHIS_I_ADDR;
            ibit_d = 4'h0;
            pull_d = 1'b0;
        end else begin
            unique case (ist_q)
                DHIS_I_IDLE: ;
                DHIS_I_ADDR: begin
                    if (scl_rise) begin
                        ish_d  = {ish_q[6:0], sda_in};
                        ibit_d = ibit_q + 4'h1;
                    end
                    if (scl_fall && ibit_q == 4'h8) begin
                        if (ish_q[7:1] == i2c_address_q) begin
                            ist_d  = DHIS_I_ACK;
                            pull_d = 1'b1;
                        end else begin
                            ist_d = DHIS_I_SKIP;
                        end
                    end
                end
                DHIS_I_ACK: begin
                    if (scl_fall) begin
                        ist_d  = DHIS_I_SKIP;
                        pull_d = 1'b0;
                    end
                end
                DHIS_I_SKIP: ;
                default: ist_d = DHIS_I_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ist_q      <= DHIS_I_IDLE;
            ish_q      <= 8'h00;
            ibit_q     <= 4'h0;
            pull_q     <= 1'b0;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            ist_q      <= ist_d;
            ish_q      <= ish_d;
            ibit_q     <= ibit_d;
            pull_q     <= pull_d;
            scl_prev_q <= scl_in;
            sda_prev_q <= sda_in;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe  = pull_q;

    chk_par_no_serial: assert property (@(posedge clk) disable iff (rst)
        is_par |-> !serial_out_oe) else $error("serial out driven in parallel mode");
    chk_sda_low_only: assert property (@(posedge clk) disable iff (rst)
        sda_oe |-> (sda_out == 1'b0 && is_i2c)) else $error("sda driven high");
    chk_pd_stage: assert property (@(posedge clk) disable iff (rst)
        pd |=> (low_power_q && out_stage_q == $past(pd_config))) else $error("pd stage");
    chk_mode_par: assert property (@(posedge clk) disable iff (rst)
        !ser |=> mode_q == 2'(dhis_pkg::DHIS_PARALLEL)) else $error("mode not parallel");
    chk_mode_ser: assert property (@(posedge clk) disable iff (rst)
        ser && !proto |=> mode_q == 2'(dhis_pkg::DHIS_SPI)) else $error("mode not spi");
    chk_wr_cs: assert property (@(posedge clk) disable iff (rst)
        (is_par && wr_rise && cs_n) |=> !wr_valid_q) else $error("write without select");
    chk_wr_par: assert property (@(posedge clk) disable iff (rst)
        (is_par && wr_rise && !cs_n && !pd && a_s2_q < 6'd40) |=> wr_valid_q)
        else $error("parallel write lost");
    chk_bank_a: assert property (@(posedge clk) disable iff (rst)
        wr_valid_q && !$past(tog_s2_q) |-> !wr_bank_b_q) else $error("bank b in normal mode");
endmodule
`default_nettype wire

// File: bench/dhis_host_model.sv
// dhis_host_model: host side of the spi port, one frame per call of send
// assumes the caller leaves the device time to answer between frames
`default_nettype none
module dhis_host_model (
    output logic sclk,
    output logic din,
    output logic frame_sync_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // 125 ns link clock, stands still high outside frames
    localparam real HALF_NS = 62.5;
    initial begin
        sclk = 1'b1;
        din = 1'b1;
        frame_sync_n = 1'b1;
    end
    task automatic send(input logic [23:0] word);
        // odd lead keeps the link clock out of phase with clk
        #3.7;
        frame_sync_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            din = word[i];
            #(HALF_NS) sclk = 1'b0;
            #(HALF_NS) sclk = 1'b1;
        end
        #(HALF_NS) frame_sync_n = 1'b1;
        // released line must not keep looking like valid data
        din = ~word[0];
    endtask
endmodule
`default_nettype wire

// File: bench/dhis_top_tb_top.sv
// dhis_top_tb_top: self-checking bench for dhis_top with a host spi model
// assumes 50 MHz clk, sync reset, link clock made by the host model
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module dhis_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0, rst = 1'b1, strap = 1'b0, pd = 1'b0, wr_n = 1'b1, cs_n = 1'b1;
    logic        tgl = 1'b0, ld_n = 1'b1, rsh = 1'b0, rsl = 1'b0, use_host = 1'b0;
    logic [1:0]  pdcfg = 2'h0;
    logic [5:0]  ch = 6'h00;
    logic [11:0] pbus = 12'h000;
    logic        h_sclk, h_din, h_sync_n, sda_out, sda_oe, so, so_oe, wv, wbb, bba, lp, abo;
    logic [1:0]  mode, wreg, ostage;
    logic [5:0]  wch;
    logic [11:0] wdat;
    logic [6:0]  i2ca;
    logic [15:0] lfsr_q = 16'd48482;
    int          n_mismatch = 0, checks = 0, n_valid = 0, n_base = 0;
    wire logic [11:0] bus_w = use_host ? {h_din, h_sclk, pbus[9:0]} : pbus;
    wire logic        cs_w = use_host ? h_sync_n : cs_n;

    always #10 clk = ~clk;
    // one-cycle pulse is counted mid-cycle, away from the edge that launches it
    always @(negedge clk) if (wv === 1'b1) n_valid++;

    dhis_host_model host_u (.sclk(h_sclk), .din(h_din), .frame_sync_n(h_sync_n));
    dhis_top dut_u (
        .clk(clk), .rst(rst), .spi_clk(h_sclk), .interface_kind_strap(strap),
        .power_down_pin(pd), .channel_address_inputs(ch), .register_select_high(rsh),
        .register_select_low(rsl), .parallel_data_bus(bus_w), .sda_out(sda_out),
        .sda_oe(sda_oe), .write_strobe_n(wr_n), .chip_select_n(cs_w), .toggle_enable(tgl),
        .load_outputs_strobe_n(ld_n), .pd_config(pdcfg), .serial_out(so),
        .serial_out_oe(so_oe), .ab_select_oe(abo), .mode_q(mode), .wr_valid_q(wv),
        .wr_channel_q(wch), .wr_register_q(wreg), .wr_bank_b_q(wbb), .wr_data_q(wdat),
        .bank_b_active_q(bba), .low_power_q(lp), .out_stage_q(ostage), .i2c_address_q(i2ca));

    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pwrite(input logic [5:0] c, input logic [1:0] r, input logic [11:0] d,
                          input logic csv);
        n_base = n_valid;
        ch = c;
        {rsh, rsl} = r;
        pbus = d;
        cs_n = csv;
        wr_n = 1'b0;
        step(3);
        wr_n = 1'b1;
        step(10);
        cs_n = 1'b1;
        step(1);
    endtask
    task automatic expect_wr(input int n, input logic [5:0] c, input logic [1:0] r,
                             input logic [11:0] d);
        `CHK("write count", n, n_valid - n_base)
        if (n == 1) begin
            `CHK("channel", c, wch)
            `CHK("register", r, wreg)
            `CHK("data", d, wdat)
            `CHK("bank b", 1'b0, wbb)
        end
    endtask
    task automatic pulse_load(input logic exp_bank);
        ld_n = 1'b0;
        step(3);
        ld_n = 1'b1;
        step(6);
        `CHK("bank active", exp_bank, bba)
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #200_000;
        n_mismatch++;
        $display("watchdog expired");
        end_of_test();
    end

    initial begin
        logic [23:0] w;
        logic [1:0]  rg;
        logic [5:0]  c;
        step(4);
        rst = 1'b0;
        step(3);
        for (int i = 0; i < 4; i++) begin
            strap = i[1];
            pbus[9] = i[0];
            step(6);
            `CHK("mode", (i < 2) ? 0 : (i[0] ? 2 : 1), mode)
        end
        n_base = n_valid;
        for (int a = 0; a < 4; a++) begin
            {wr_n, cs_n} = a[1:0];
            step(6);
            `CHK("i2c address", {dhis_pkg::I2C_ADDR_BASE, a[1:0]}, i2ca)
            `CHK("sda level", 1'b0, sda_out)
            `CHK("sda pull idle", 1'b0, sda_oe)
        end
        `CHK("i2c strobes", 0, n_valid - n_base)
        {wr_n, cs_n, strap, pbus} = {3'b110, 12'h000};
        step(6);
        $display("test modes done");
        for (int k = 0; k < 12; k++) begin
            lfsr_q = lfsr_next(lfsr_q);
            c = 6'(lfsr_q[5:0] % 40);
            rg = lfsr_q[7:6];
            lfsr_q = lfsr_next(lfsr_q);
            pwrite(c, rg, lfsr_q[11:0], 1'b0);
            expect_wr(1, c, rg, lfsr_q[11:0]);
        end
        pwrite(6'd39, 2'h3, 12'hfff, 1'b0);
        expect_wr(1, 6'd39, 2'h3, 12'hfff);
        pwrite(6'd40, 2'h3, 12'h123, 1'b0);
        expect_wr(0, 6'd40, 2'h3, 12'h123);
        pwrite(6'd40, 2'h0, 12'h5a5, 1'b0);
        expect_wr(1, 6'd40, 2'h0, 12'h5a5);
        pwrite(6'd3, 2'h3, 12'h0a0, 1'b1);
        expect_wr(0, 6'd3, 2'h3, 12'h0a0);
        `CHK("serial oe par", 1'b0, so_oe)
        `CHK("ab select oe", 1'b0, abo)
        $display("test parallel done");
        for (int p = 0; p < 2; p++) begin
            pd = 1'b1;
            pdcfg = 2'(p);
            step(6);
            `CHK("low power", 1'b1, lp)
            `CHK("out stage", 2'(p), ostage)
            pwrite(6'd5, 2'h3, 12'h777, 1'b0);
            expect_wr(0, 6'd5, 2'h3, 12'h777);
        end
        pd = 1'b0;
        step(6);
        `CHK("out stage", dhis_pkg::PD_ACTIVE, ostage)
        tgl = 1'b1;
        pulse_load(1'b1);
        pulse_load(1'b0);
        pulse_load(1'b1);
        tgl = 1'b0;
        step(6);
        `CHK("bank forced a", 1'b0, bba)
        $display("test power and toggle done");
        strap = 1'b1;
        use_host = 1'b1;
        pbus = 12'h000;
        wr_n = 1'b0;
        step(6);
        for (int k = 0; k < 5; k++) begin
            lfsr_q = lfsr_next(lfsr_q);
            c = 6'(lfsr_q[5:0] % 40);
            rg = lfsr_q[7:6];
            pd = (k == 4);
            lfsr_q = lfsr_next(lfsr_q);
            w = {2'b00, rg, 2'b00, c, lfsr_q[11:0]};
            n_base = n_valid;
            host_u.send(w);
            step(8);
            expect_wr(1, c, rg, lfsr_q[11:0]);
            `CHK("serial oe unchained", 1'b0, so_oe)
        end
        pd = 1'b0;
        pwrite(6'd2, 2'h3, 12'h0f0, 1'b0);
        expect_wr(0, 6'd2, 2'h3, 12'h0f0);
        $display("test spi done");
        end_of_test();
    end
endmodule
`undef CHK
`default_nettype wire
